// *** common/ihb_if.sv ***
// Pin-level connection between the host end and the device end
`timescale 1ns/1ps
`include "ihb_params.svh"
interface ihb_if;
  logic [15:0] host_bus_out;    // Host drive value
  logic        host_bus_oe;     // Host drives shared bus
  logic [15:0] dev_bus_out;     // Device drive value
  logic        dev_bus_oe;      // Device drives shared bus
  logic [15:0] shared_bus;      // Resolved wire level
  logic        cmd_sel;         // Cycle type select
  logic        chip_select_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic        irq_out_n;

  // Resolve the wire; pull-ups give all ones when undriven
  assign shared_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : `IHB_IDLE_BUS);

  modport dev (
    input  shared_bus, cmd_sel, chip_select_n, read_strobe_n, write_strobe_n,
    output dev_bus_out, dev_bus_oe, irq_out_n
  );

  modport host (
    input  shared_bus, irq_out_n,
    output host_bus_out, host_bus_oe, cmd_sel, chip_select_n, read_strobe_n, write_strobe_n
  );
endinterface : ihb_if

// *** common/ihb_params.svh ***
// Constants for the indirect host bus port: fields, resets and timing
`ifndef IHB_PARAMS_SVH
`define IHB_PARAMS_SVH

// Cycle type select values
`define IHB_CMD_DATA     1'b0
`define IHB_CMD_ADDR     1'b1

// Command word fields in 16-bit mode
`define IHB_BE_HI        15
`define IHB_BE_LO        12
`define IHB_A_HI         10
`define IHB_A_LO         2

// Second 8-bit command write carries the top address bits
`define IHB_A8_HI        2

// Endian select bit inside the receive frame pointer register
`define IHB_RXFP_ADDR    11'h0_084
`define IHB_ENDIAN_BIT   11

// Reset values
`define IHB_ADDR_RST     11'h0_00
`define IHB_BE_RST       4'h0
`define IHB_DATA_RST     16'h0000
`define IHB_WORD_RST     32'h0000_0000
`define IHB_IDLE_BUS     16'hFFFF

// Host strobe timing
`define IHB_CLK_NS       50
`define IHB_STROBE_NS    150
`define IHB_STROBE_CYC   ((`IHB_STROBE_NS + `IHB_CLK_NS - 1) / `IHB_CLK_NS)

`endif

// *** common/ihb_pkg.sv ***
// Types shared by both ends of the indirect host bus port
package ihb_pkg;

  // Register space address
  typedef logic [10:0] ihb_addr_t;

  // Host end cycle sequencer
  typedef enum logic [1:0] {
    IHB_IDLE,
    IHB_SETUP,
    IHB_STROBE,
    IHB_HOLD
  } ihb_state_t;

endpackage : ihb_pkg

// *** hw/ihb_device.sv ***
// Device end of the indirect host bus port
`timescale 1ns/1ps
`include "ihb_params.svh"
module ihb_device (
  // Clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_rst_n,
  // Pins
  ihb_if.dev                       bus,
  input  wire logic                i_bus16,
  input  wire logic                i_port2_indicator0_strap,
  // Interrupt request from the core
  input  wire logic                i_irq_req,
  // Register space side
  output logic                     o_reg_wr,
  output logic                     o_reg_rd,
  output ihb_pkg::ihb_addr_t       o_reg_addr,
  output logic [3:0]               o_lane_enables,
  output logic [31:0]              o_reg_wdata,
  input  wire logic [31:0]         i_reg_rdata,
  // Status
  output logic                     o_big_endian
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte order within a 16-bit lane pair
  function automatic logic [15:0] swap16(input logic big, input logic [15:0] d);
    swap16 = big ? {d[7:0], d[15:8]} : d;
  endfunction : swap16

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic                wr_q;
  logic                rd_q;
  ihb_pkg::ihb_addr_t  addr;
  logic [3:0]          lanes;
  logic                phase_hi;
  logic                strap_taken;
  logic                strap_big;
  logic                ovr_valid;
  logic                ovr_big;
  logic [15:0]         rd_data;
  logic                irq_n;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         wdata;
  logic                next_wr_q;
  logic                next_rd_q;
  ihb_pkg::ihb_addr_t  next_addr;
  logic [3:0]          next_lanes;
  logic                next_phase_hi;
  logic                next_strap_taken;
  logic                next_strap_big;
  logic                next_ovr_valid;
  logic                next_ovr_big;
  logic [15:0]         next_rd_data;
  logic                next_irq_n;
  logic                next_reg_wr;
  logic                next_reg_rd;
  logic [31:0]         next_wdata;

  // Decoded strobes and data paths
  logic                selected;
  logic                wr_fall;
  logic                rd_fall;
  logic                big;
  logic                hi_half;
  logic [3:0]          eff_lanes;
  logic [15:0]         sw_in;
  logic [15:0]         word_lo;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe qualification and lane decode
  assign selected  = !bus.chip_select_n;
  assign wr_fall   = selected && !bus.write_strobe_n && wr_q;
  assign rd_fall   = selected && !bus.read_strobe_n && rd_q;
  assign big       = ovr_valid ? ovr_big : strap_big;
  // Upper pair chosen only when no lower lane is enabled
  assign hi_half   = (lanes[1:0] == 2'b00) && (lanes[3:2] != 2'b00);
  // 8-bit mode: one byte lane from the low address bits
  assign eff_lanes = i_bus16 ? lanes : (4'h1 << addr[1:0]);
  assign sw_in     = swap16(big, bus.shared_bus);
  assign word_lo   = hi_half ? i_reg_rdata[31:16] : i_reg_rdata[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_wr_q        = bus.write_strobe_n;
    next_rd_q        = bus.read_strobe_n;
    next_addr        = addr;
    next_lanes       = lanes;
    next_phase_hi    = phase_hi;
    next_strap_taken = 1'b1;
    next_strap_big   = strap_big;
    next_ovr_valid   = ovr_valid;
    next_ovr_big     = ovr_big;
    next_rd_data     = rd_data;
    next_irq_n       = !i_irq_req;
    next_reg_wr      = 1'b0;
    next_reg_rd      = 1'b0;
    next_wdata       = wdata;
    // Strap caught on the first edge after reset release
    if (!strap_taken)
    begin
      next_strap_big = !i_port2_indicator0_strap;
    end
    if (wr_fall && bus.cmd_sel == `IHB_CMD_ADDR)
    begin
      if (i_bus16)
      begin
        // 16-bit command word
        next_addr  = {bus.shared_bus[`IHB_A_HI:`IHB_A_LO], 2'b00};
        next_lanes = bus.shared_bus[`IHB_BE_HI:`IHB_BE_LO];
      end
      else if (!phase_hi)
      begin
        // First 8-bit write: low address byte
        next_addr     = {addr[10:8], bus.shared_bus[7:0]};
        next_phase_hi = 1'b1;
      end
      else
      begin
        // Second 8-bit write: top three address bits
        next_addr     = {bus.shared_bus[`IHB_A8_HI:0], addr[7:0]};
        next_phase_hi = 1'b0;
      end
    end
    else if (wr_fall)
    begin
      // Data write; half-word placed in both halves (16-bit) or byte in all four lanes (8-bit), lanes pick
      next_reg_wr = 1'b1;
      if (i_bus16)
      begin
        next_wdata = {sw_in, sw_in};
      end
      else
      begin
        next_wdata = {4{bus.shared_bus[7:0]}};
      end
    end
    // Reads of data fetch the addressed word through the core
    if (rd_fall && bus.cmd_sel == `IHB_CMD_DATA)
    begin
      next_reg_rd = 1'b1;
    end
    else if (rd_fall && i_bus16)
    begin
      // Command readback only meaningful in 16-bit mode
      next_rd_data = {lanes, 1'b0, addr[`IHB_A_HI:`IHB_A_LO], 2'b00};
    end
    if (reg_rd)
    begin
      if (i_bus16)
      begin
        next_rd_data = swap16(big, word_lo);
      end
      else
      begin
        next_rd_data = {8'h00, i_reg_rdata[8 * addr[1:0] +: 8]};
      end
    end
    // Endian override taken when the core sees the pointer write
    if (reg_wr && addr == `IHB_RXFP_ADDR && eff_lanes[1])
    begin
      next_ovr_valid = 1'b1;
      next_ovr_big   = wdata[`IHB_ENDIAN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_q        <= 1'b1;
      rd_q        <= 1'b1;
      addr        <= `IHB_ADDR_RST;
      lanes       <= `IHB_BE_RST;
      phase_hi    <= 1'b0;
      strap_taken <= 1'b0;
      strap_big   <= 1'b0;
      ovr_valid   <= 1'b0;
      ovr_big     <= 1'b0;
      rd_data     <= `IHB_DATA_RST;
      irq_n       <= 1'b1;
      reg_wr      <= 1'b0;
      reg_rd      <= 1'b0;
      wdata       <= `IHB_WORD_RST;
    end
    else
    begin
      wr_q        <= next_wr_q;
      rd_q        <= next_rd_q;
      addr        <= next_addr;
      lanes       <= next_lanes;
      phase_hi    <= next_phase_hi;
      strap_taken <= next_strap_taken;
      strap_big   <= next_strap_big;
      ovr_valid   <= next_ovr_valid;
      ovr_big     <= next_ovr_big;
      rd_data     <= next_rd_data;
      irq_n       <= next_irq_n;
      reg_wr      <= next_reg_wr;
      reg_rd      <= next_reg_rd;
      wdata       <= next_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins; drive only a qualified read so the host is never fought
  assign bus.dev_bus_oe  = selected && !bus.read_strobe_n &&
                           (bus.cmd_sel == `IHB_CMD_DATA || i_bus16);
  assign bus.dev_bus_out = i_bus16 ? rd_data : {8'h00, rd_data[7:0]};
  assign bus.irq_out_n   = irq_n;

  // Core side; the full 11-bit space is reachable
  assign o_reg_wr       = reg_wr;
  assign o_reg_rd       = reg_rd;
  assign o_reg_addr     = addr;
  assign o_lane_enables = eff_lanes;
  assign o_reg_wdata    = wdata;
  assign o_big_endian   = big;

endmodule : ihb_device

// *** hw/ihb_host.sv ***
// Host end of the indirect host bus port
`timescale 1ns/1ps
`include "ihb_params.svh"
module ihb_host #(
  parameter int STROBE_CYC = `IHB_STROBE_CYC
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  // Pins
  ihb_if.host               bus,
  input  wire logic         i_bus16,
  // Request
  input  wire logic         i_req,
  input  wire logic         i_req_write,
  input  wire logic         i_req_cmd,
  input  wire logic [15:0]  i_req_data,
  output logic              o_ready,
  // Answer
  output logic              o_rsp_valid,
  output logic [15:0]       o_rsp_data,
  output logic              o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  ihb_pkg::ihb_state_t state;
  ihb_pkg::ihb_state_t next_state;
  logic [7:0]          cnt;
  logic [7:0]          next_cnt;
  logic                wr;
  logic                next_wr;
  logic                cmd;
  logic                next_cmd;
  logic [15:0]         dout;
  logic [15:0]         next_dout;
  logic                rsp_valid;
  logic                next_rsp_valid;
  logic [15:0]         rsp_data;
  logic [15:0]         next_rsp_data;
  logic                next_rsp_data_en;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: setup, strobe low, hold
  always_comb
  begin
    next_state       = state;
    next_cnt         = cnt;
    next_wr          = wr;
    next_cmd         = cmd;
    next_dout        = dout;
    next_rsp_valid   = 1'b0;
    next_rsp_data_en = 1'b0;
    unique case (state)
      ihb_pkg::IHB_IDLE:
      begin
        if (i_req)
        begin
          // Command cycle must precede data cycles to the register
          next_state = ihb_pkg::IHB_SETUP;
          next_wr    = i_req_write;
          next_cmd   = i_req_cmd;
          // 8-bit hosts use only the low lanes
          next_dout  = i_bus16 ? i_req_data : {8'h00, i_req_data[7:0]};
        end
      end
      ihb_pkg::IHB_SETUP:
      begin
        next_state = ihb_pkg::IHB_STROBE;
        next_cnt   = 8'(STROBE_CYC - 1);
      end
      ihb_pkg::IHB_STROBE:
      begin
        if (cnt == 8'h00)
        begin
          // Read data latched as the strobe rises
          next_state       = ihb_pkg::IHB_HOLD;
          next_rsp_data_en = !wr;
          next_rsp_valid   = !wr;
        end
        else
        begin
          next_cnt = cnt - 8'h01;
        end
      end
      ihb_pkg::IHB_HOLD:
      begin
        next_state = ihb_pkg::IHB_IDLE;
      end
    endcase
    // Read data taken only on the closing edge of a read strobe
    next_rsp_data = next_rsp_data_en ? bus.shared_bus : rsp_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state     <= ihb_pkg::IHB_IDLE;
      cnt       <= 8'h00;
      wr        <= 1'b0;
      cmd       <= `IHB_CMD_DATA;
      dout      <= `IHB_DATA_RST;
      rsp_valid <= 1'b0;
      rsp_data  <= `IHB_DATA_RST;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      wr        <= next_wr;
      cmd       <= next_cmd;
      dout      <= next_dout;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins; chip select spans setup through hold
  assign bus.chip_select_n  = (state == ihb_pkg::IHB_IDLE);
  assign bus.cmd_sel        = cmd;
  assign bus.write_strobe_n = !(state == ihb_pkg::IHB_STROBE && wr);
  assign bus.read_strobe_n  = !(state == ihb_pkg::IHB_STROBE && !wr);
  assign bus.host_bus_oe    = wr && (state != ihb_pkg::IHB_IDLE);
  assign bus.host_bus_out   = dout;

  // User side
  assign o_ready     = (state == ihb_pkg::IHB_IDLE);
  assign o_rsp_valid = rsp_valid;
  assign o_rsp_data  = rsp_data;
  assign o_irq       = !bus.irq_out_n;

endmodule : ihb_host

// *** testbench/ihb_sva.sv ***
// Pin-level assertions between the host end and the device end
`timescale 1ns/1ps
module ihb_sva (
  // Clock, reset, mode and interrupt request
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_bus16,
  input wire logic        i_irq_req,
  // Shared pins
  input wire logic [15:0] host_bus_out,
  input wire logic        host_bus_oe,
  input wire logic [15:0] dev_bus_out,
  input wire logic        dev_bus_oe,
  input wire logic        cmd_sel,
  input wire logic        chip_select_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic        irq_out_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////
  // Read strobe that the device must answer
  sequence rd_take;
    $fell(read_strobe_n) && !chip_select_n && (!cmd_sel || i_bus16);
  endsequence
  // Strobe follows one cycle after select, giving setup time
  sequence strobe_next;
    ##1 (!read_strobe_n || !write_strobe_n);
  endsequence

  ////////////////////////////////////////////////////////////
  dev_drive_a: assert property (dev_bus_oe == (!chip_select_n && !read_strobe_n && (!cmd_sel || i_bus16)))
    else $error("device drive does not match select and strobe");
  bus_clash_a: assert property (!(host_bus_oe && dev_bus_oe))
    else $error("both ends drive the shared bus");
  irq_follow_a: assert property ($past(i_rst_n) |-> irq_out_n == !$past(i_irq_req))
    else $error("interrupt output does not follow request");
  rd_hold_a: assert property (rd_take |-> ##2 (dev_bus_oe && !read_strobe_n))
    else $error("read data not driven before strobe rises");
  rd_width_a: assert property ($fell(read_strobe_n) |-> (!read_strobe_n)[*3] ##1 read_strobe_n)
    else $error("read strobe width wrong");
  wr_setup_a: assert property ($fell(write_strobe_n) |->
    host_bus_oe && !chip_select_n && $stable(host_bus_out) && $stable(cmd_sel))
    else $error("write data not set up at strobe fall");
  cs_frame_a: assert property ($fell(chip_select_n) |-> strobe_next)
    else $error("no strobe after select");
  cs_close_a: assert property ($rose(chip_select_n) |-> $past(read_strobe_n) && $past(write_strobe_n))
    else $error("select released under an active strobe");
  narrow_lanes_a: assert property (dev_bus_oe && !i_bus16 |-> dev_bus_out[15:8] == 8'h00)
    else $error("device drove upper lanes in byte mode");
  byte_cmd_rd_a: assert property (!i_bus16 && cmd_sel |-> !dev_bus_oe)
    else $error("device answered a byte mode command read");
endmodule : ihb_sva

// *** testbench/tb_indirect_async_host_bus_port.sv ***
// Self-checking bench joining host end and device end
`timescale 1ns/1ps
module tb_indirect_async_host_bus_port;
  typedef struct packed {
    logic        w;
    logic        cmd;
    logic [15:0] data;
    logic [31:0] rdata;
    logic [10:0] addr;
    logic [3:0]  lanes;
    logic [31:0] val;
  } ihb_row_t;

  // Bench signals
  logic        core_clk, rst_n, bus16, strap, irq_req;
  logic        req, req_write, req_cmd, ready, rsp_valid, irq;
  logic [15:0] req_data, rsp_data, got_rsp;
  logic        reg_wr, reg_rd, big_endian, got_wr, got_rd;
  logic [10:0] reg_addr;
  logic [3:0]  lanes;
  logic [31:0] reg_wdata, reg_rdata, got_wdata;
  int          fails, compares;
  ihb_row_t    rows [8];

  ////////////////////////////////////////////////////////////
  // Both ends face each other through the pin interface
  ihb_if i_ihb_if ();
  ihb_device i_ihb_device (.i_core_clk(core_clk), .i_rst_n(rst_n), .bus(i_ihb_if), .i_bus16(bus16),
    .i_port2_indicator0_strap(strap), .i_irq_req(irq_req), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_addr(reg_addr), .o_lane_enables(lanes), .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata),
    .o_big_endian(big_endian));
  ihb_host i_ihb_host (.i_core_clk(core_clk), .i_rst_n(rst_n), .bus(i_ihb_if), .i_bus16(bus16),
    .i_req(req), .i_req_write(req_write), .i_req_cmd(req_cmd), .i_req_data(req_data), .o_ready(ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_irq(irq));
  ihb_sva i_ihb_sva (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_bus16(bus16), .i_irq_req(irq_req),
    .host_bus_out(i_ihb_if.host_bus_out), .host_bus_oe(i_ihb_if.host_bus_oe),
    .dev_bus_out(i_ihb_if.dev_bus_out), .dev_bus_oe(i_ihb_if.dev_bus_oe), .cmd_sel(i_ihb_if.cmd_sel),
    .chip_select_n(i_ihb_if.chip_select_n), .read_strobe_n(i_ihb_if.read_strobe_n),
    .write_strobe_n(i_ihb_if.write_strobe_n), .irq_out_n(i_ihb_if.irq_out_n));

  // 20 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic stop_test;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Mode and strap only change while reset is held
  task automatic do_reset(input logic b16, input logic s);
    rst_n = 1'b0;
    bus16 = b16;
    strap = s;
    repeat (12) @(posedge core_clk);
    #5 rst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #5;
  endtask : do_reset

  // One host cycle; results captured while the pulses stand
  task automatic op(input logic w, input logic c, input logic [15:0] d);
    got_wr = 1'b0;
    got_rd = 1'b0;
    got_wdata = 'x;
    got_rsp = 'x;
    req = 1'b1;
    req_write = w;
    req_cmd = c;
    req_data = d;
    @(posedge core_clk);
    #5 req = 1'b0;
    repeat (10)
    begin
      @(posedge core_clk);
      #5;
      if (reg_wr === 1'b1)
      begin
        got_wr = 1'b1;
        got_wdata = reg_wdata;
      end
      if (reg_rd === 1'b1)
        got_rd = 1'b1;
      if (rsp_valid === 1'b1)
        got_rsp = rsp_data;
    end
    if (ready !== 1'b1)
    begin
      fails++;
      $display("BAD ready expected 1 seen %b", ready);
      stop_test();
    end
  endtask : op

  ////////////////////////////////////////////////////////////
  initial
  begin
    fails = 0;
    compares = 0;
    irq_req = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_cmd = 1'b0;
    req_data = 16'h0000;
    reg_rdata = 32'h0000_0000;
    // Write, cmd, data, read word, address, lanes, expected value
    rows[0] = '{1'b1, 1'b1, 16'h30D0, 32'h0000_0000, 11'h0D0, 4'h3, 32'h0000_0000};
    rows[1] = '{1'b1, 1'b0, 16'hA5C3, 32'h0000_0000, 11'h0D0, 4'h3, 32'hA5C3_A5C3};
    rows[2] = '{1'b0, 1'b0, 16'h0000, 32'h1234_5678, 11'h0D0, 4'h3, 32'h0000_5678};
    rows[3] = '{1'b0, 1'b1, 16'h0000, 32'h0000_0000, 11'h0D0, 4'h3, 32'h0000_30D0};
    rows[4] = '{1'b1, 1'b1, 16'hC7FC, 32'h0000_0000, 11'h7FC, 4'hC, 32'h0000_0000};
    rows[5] = '{1'b0, 1'b0, 16'h0000, 32'hBEEF_1234, 11'h7FC, 4'hC, 32'h0000_BEEF};
    rows[6] = '{1'b1, 1'b1, 16'h1FFF, 32'h0000_0000, 11'h7FC, 4'h1, 32'h0000_0000};
    rows[7] = '{1'b0, 1'b0, 16'h0000, 32'hCAFE_F00D, 11'h7FC, 4'h1, 32'h0000_F00D};
    do_reset(1'b1, 1'b1);
    chk("endian", 32'h0000_0000, {31'h0, big_endian});
    chk("addr", 32'h0000_0000, {21'h0, reg_addr});
    chk("lanes", 32'h0000_0000, {28'h0, lanes});
    // Table of 16-bit little-endian cycles
    for (int i = 0; i < 8; i++)
    begin
      reg_rdata = rows[i].rdata;
      op(rows[i].w, rows[i].cmd, rows[i].data);
      chk("addr", {21'h0, rows[i].addr}, {21'h0, reg_addr});
      chk("lanes", {28'h0, rows[i].lanes}, {28'h0, lanes});
      chk("rd", {31'h0, !rows[i].w && !rows[i].cmd}, {31'h0, got_rd});
      if (rows[i].cmd)
        chk("wr", 32'h0000_0000, {31'h0, got_wr});
      if (rows[i].w && !rows[i].cmd)
      begin
        chk("wr", 32'h0000_0001, {31'h0, got_wr});
        chk("wdata", rows[i].val, got_wdata);
      end
      if (!rows[i].w)
        chk("rsp", rows[i].val, {16'h0000, got_rsp});
    end
    $display("test rows done");
    // Interrupt raised then dropped
    irq_req = 1'b1;
    repeat (2) @(posedge core_clk);
    #5 chk("irq", 32'h0000_0001, {31'h0, irq});
    irq_req = 1'b0;
    repeat (2) @(posedge core_clk);
    #5 chk("irq", 32'h0000_0000, {31'h0, irq});
    $display("test interrupt done");
    // Endian override through the pointer register, then a swapped read
    op(1'b1, 1'b1, 16'h2084);
    op(1'b1, 1'b0, 16'h0800);
    chk("endian", 32'h0000_0001, {31'h0, big_endian});
    reg_rdata = 32'h0000_A1B2;
    op(1'b0, 1'b0, 16'h0000);
    chk("rsp", 32'h0000_B2A1, {16'h0000, got_rsp});
    do_reset(1'b1, 1'b0);
    chk("endian", 32'h0000_0001, {31'h0, big_endian});
    chk("addr", 32'h0000_0000, {21'h0, reg_addr});
    $display("test endian done");
    // Byte mode: two-part address with junk in unused lines
    do_reset(1'b0, 1'b1);
    op(1'b1, 1'b1, 16'h0037);
    op(1'b1, 1'b1, 16'h00FD);
    chk("addr", 32'h0000_0537, {21'h0, reg_addr});
    chk("lanes", 32'h0000_0008, {28'h0, lanes});
    op(1'b1, 1'b0, 16'h005A);
    chk("wdata", 32'h5A5A_5A5A, got_wdata);
    reg_rdata = 32'h1122_3344;
    op(1'b0, 1'b0, 16'h0000);
    chk("rsp", 32'h0000_0011, {24'h0, got_rsp[7:0]});
    // Byte mode command read is not answered; pull-ups show through
    op(1'b0, 1'b1, 16'h0000);
    chk("rsp", 32'h0000_FFFF, {16'h0000, got_rsp});
    $display("test byte mode done");
    stop_test();
  end
endmodule : tb_indirect_async_host_bus_port
